// ==== hdl/occ_console.sv ====
// Function
// RL1 - Reset key forces fetch phase and resets I/O and power-fail systems.
// RL2 - Reset key clears the interrupt master enable.
// RL3 - I/O cards: clear attention and enable latches, then set attention latches.
// RL4 - Reset clears power-fail attention buffer, attention and request latches.
// RL5 - Run lamp latches on power-up, power fail, overheat until reset.
// RL6 - Run key starts in shown phase from program counter; lamp lit.
// RL7 - Stop key halts at end of phase; stop lamp lit when idle.
// RL8 - Deposit writes switch word at address, bumps counter, copies to address.
// RL9 - Load keys copy the switch word into either accumulator.
// RL10 - Set-address copies switch word into address and counter, fetch phase.
// RL11 - Examine reads core into data register, bumps counter, copies to address.
// RL12 - Single-step runs exactly one machine cycle then stops.
// RL13 - Switch word bit 0 is least significant; up reads one.
// RL14 - All keys except stop are ignored while a program runs.
// RL15 - Loader region reachable only with unlock switch enabled.
// RL16 - Lamps follow carry extension, overflow and one-hot phase.
// RL17 - Lamp rows show data, counter, address and both accumulators.
// RL18 - Keys are synchronised, debounced and act once per press.
//
// Added by the designer: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module occ_console #(
    parameter int unsigned DEB_CYCLES = occ_pkg::DEB_CYC
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // AHB-Lite slave
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic hreadyout_out,
    output logic hresp_out,
    output logic [31:0] hrdata_out,
    // Operator panel
    input wire logic [occ_pkg::NUM_KEYS-1:0] key_in,
    input wire logic [occ_pkg::WORD_W-1:0] switch_in,
    input wire logic loader_en_in,
    input wire logic pfail_in,
    input wire logic overheat_in,
    // Processor state
    input wire logic [2:0] phase_in,
    input wire logic phase_end_in,
    input wire logic ext_in,
    input wire logic ovf_in,
    input wire logic [occ_pkg::WORD_W-1:0] mdr_in,
    input wire logic [occ_pkg::WORD_W-1:0] pc_in,
    input wire logic [occ_pkg::WORD_W-1:0] mar_in,
    input wire logic [occ_pkg::WORD_W-1:0] acc_a_in,
    input wire logic [occ_pkg::WORD_W-1:0] acc_b_in,
    // Processor control
    output logic run_out,
    output logic force_fetch_out,
    output var occ_pkg::occ_cmd_type cmd_out,
    output logic cmd_valid_out,
    output logic [occ_pkg::WORD_W-1:0] cmd_data_out,
    input wire logic cmd_done_in,
    output logic loader_ok_out,
    // Reset fan-out
    output logic io_clear_out,
    output logic io_set_out,
    output logic ime_clear_out,
    output logic pfi_clear_out,
    // Lamps
    output logic run_lamp_out,
    output logic stop_lamp_out,
    output logic ext_lamp_out,
    output logic ovf_lamp_out,
    output logic [2:0] phase_lamp_out,
    output logic [occ_pkg::WORD_W-1:0] mdr_lamp_out,
    output logic [occ_pkg::WORD_W-1:0] pc_lamp_out,
    output logic [occ_pkg::WORD_W-1:0] mar_lamp_out,
    output logic [occ_pkg::WORD_W-1:0] acc_a_lamp_out,
    output logic [occ_pkg::WORD_W-1:0] acc_b_lamp_out
);
    import occ_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RCLR = 3'b001,
        ST_RSET = 3'b010,
        ST_WAIT = 3'b011,
        ST_RUN = 3'b100,
        ST_STEP = 3'b101
    } occ_state_type;

    // ----------------------------------------------------------------
    // Key debouncers
    // ----------------------------------------------------------------
    logic [NUM_KEYS-1:0] press;
    genvar gi;
    generate
        for (gi = 0; gi < NUM_KEYS; gi++) begin : g_key
            occ_key_if kif();
            assign kif.raw = key_in[gi];
            assign press[gi] = kif.press;
            occ_debounce #(.DEB_CYCLES(DEB_CYCLES), .CNT_W(17)) u_deb (
                .clk_in(clk_in),
                .rst_b_in(rst_b_in),
                .key(kif)
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [WORD_W+2:0] p1_r, p2_r, p3_r, pin_r;
    wire [WORD_W+2:0] pin_raw = {overheat_in, pfail_in, loader_en_in, switch_in};
    wire [WORD_W+2:0] pin_agree = ~(p2_r ^ p3_r);
    wire [WORD_W-1:0] sw_word = pin_r[WORD_W-1:0]; // see RL13
    wire loader_en = pin_r[WORD_W];
    wire fault_in = pin_r[WORD_W+1] | pin_r[WORD_W+2];

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            p1_r <= '0;
            p2_r <= '0;
            p3_r <= '0;
            pin_r <= '0;
        end else begin
            p1_r <= pin_raw;
            p2_r <= p1_r;
            p3_r <= p2_r;
            pin_r <= (pin_agree & p3_r) | (~pin_agree & pin_r);
        end
    end

    // ----------------------------------------------------------------
    // Sequencer state and decode
    // ----------------------------------------------------------------
    occ_state_type state_r, state_nxt;
    logic follow_r, stop_pend_r, fault_r;
    logic [31:0] ctrl_r;
    wire idle = (state_r == ST_IDLE);
    wire keys_ok = idle && !ctrl_r[CTRL_LOCK_BIT]; // see RL14
    wire go_reset = keys_ok && press[K_RESET];
    wire go_run = keys_ok && press[K_RUN];
    wire go_dep = keys_ok && press[K_DEPOSIT];
    wire go_exa = keys_ok && press[K_EXAMINE];
    wire go_lda = keys_ok && press[K_LOAD_A];
    wire go_ldb = keys_ok && press[K_LOAD_B];
    wire go_ldm = keys_ok && press[K_SET_ADDR];
    wire go_step = keys_ok && press[K_STEP];
    wire go_cmd = go_dep | go_exa | go_lda | go_ldb | go_ldm;
    wire running = (state_r == ST_RUN) || (state_r == ST_STEP);
    wire stop_now = stop_pend_r || press[K_STOP];
    wire cmd_fin = (state_r == ST_WAIT) && cmd_done_in;

    // Key to command
    occ_cmd_type key_cmd;
    assign key_cmd = go_dep ? CMD_MEM_WR :   // see RL8
                     go_exa ? CMD_MEM_RD :   // see RL11
                     go_lda ? CMD_LD_A :     // see RL9
                     go_ldb ? CMD_LD_B :     // see RL9
                     CMD_LD_ADDR;            // see RL10

    // Next state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (go_reset)
                    state_nxt = ST_RCLR;
                else if (go_run)
                    state_nxt = ST_RUN;
                else if (go_step)
                    state_nxt = ST_STEP;
                else if (go_cmd)
                    state_nxt = ST_WAIT;
            end
            ST_RCLR: state_nxt = ST_RSET;
            ST_RSET: state_nxt = ST_IDLE;
            ST_WAIT: begin
                if (cmd_done_in && !follow_r)
                    state_nxt = ST_IDLE;
            end
            ST_RUN: begin
                if (phase_end_in && stop_now)
                    state_nxt = ST_IDLE; // see RL7
            end
            ST_STEP: begin
                if (phase_end_in)
                    state_nxt = ST_IDLE; // see RL12
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    // State and run output
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_r <= ST_IDLE;
            stop_pend_r <= 1'b0;
            run_out <= 1'b0;
        end else begin
            state_r <= state_nxt;
            stop_pend_r <= (state_r == ST_RUN) && stop_now && !phase_end_in;
            run_out <= (state_nxt == ST_RUN) || (state_nxt == ST_STEP); // see RL6
        end
    end

    // ----------------------------------------------------------------
    // Command handshake
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cmd_out <= CMD_NONE;
            cmd_valid_out <= 1'b0;
            cmd_data_out <= '0;
            follow_r <= 1'b0;
        end else if (go_cmd && !go_reset && !go_run && !go_step) begin
            cmd_out <= key_cmd;
            cmd_valid_out <= 1'b1;
            cmd_data_out <= sw_word; // see RL13
            follow_r <= go_dep | go_exa;
        end else if (cmd_fin && follow_r) begin
            cmd_out <= CMD_INC_PC; // see RL8 see RL11
            follow_r <= 1'b0;
        end else if (cmd_fin) begin
            cmd_out <= CMD_NONE;
            cmd_valid_out <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Reset fan-out pulses
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            io_clear_out <= 1'b0;
            io_set_out <= 1'b0;
            ime_clear_out <= 1'b0;
            pfi_clear_out <= 1'b0;
            force_fetch_out <= 1'b0;
        end else begin
            io_clear_out <= go_reset;           // see RL1 see RL3
            io_set_out <= (state_r == ST_RCLR); // see RL3
            ime_clear_out <= go_reset;          // see RL2
            pfi_clear_out <= go_reset;          // see RL4
            force_fetch_out <= go_reset;        // see RL1
        end
    end

    // ----------------------------------------------------------------
    // Fault latch and lamps
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            fault_r <= 1'b1;
            run_lamp_out <= 1'b0;
            stop_lamp_out <= 1'b1;
            loader_ok_out <= 1'b0;
        end else begin
            fault_r <= fault_in || (fault_r && !go_reset); // see RL5
            run_lamp_out <= fault_r || running;             // see RL5 see RL6
            stop_lamp_out <= !running;                      // see RL7
            loader_ok_out <= loader_en;                     // see RL15
        end
    end

    // Register rows and status lamps
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ext_lamp_out <= 1'b0;
            ovf_lamp_out <= 1'b0;
            phase_lamp_out <= 3'h0;
            mdr_lamp_out <= '0;
            pc_lamp_out <= '0;
            mar_lamp_out <= '0;
            acc_a_lamp_out <= '0;
            acc_b_lamp_out <= '0;
        end else begin
            ext_lamp_out <= ext_in;     // see RL16
            ovf_lamp_out <= ovf_in;     // see RL16
            phase_lamp_out <= phase_in; // see RL16
            mdr_lamp_out <= mdr_in;     // see RL17
            pc_lamp_out <= pc_in;       // see RL17
            mar_lamp_out <= mar_in;     // see RL17
            acc_a_lamp_out <= acc_a_in; // see RL17
            acc_b_lamp_out <= acc_b_in; // see RL17
        end
    end

    // ----------------------------------------------------------------
    // AHB-Lite slave
    // ----------------------------------------------------------------
    logic wr_pend_r;
    logic [7:0] wr_addr_r;
    wire take = hsel_in && htrans_in[1] && hready_in;
    wire [7:0] a8 = haddr_in[7:0];
    wire [31:0] status_word = {24'h000000, fault_r, loader_en, running,
                               state_r, 2'h0};
    wire [31:0] rd_mux = (a8 == ADDR_STATUS) ? status_word :
                         (a8 == ADDR_CTRL) ? ctrl_r :
                         (a8 == ADDR_SWITCH) ? {16'h0000, sw_word} : 32'h0000_0000;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            hrdata_out <= 32'h0000_0000;
            hreadyout_out <= 1'b1;
            hresp_out <= 1'b0;
            ctrl_r <= CTRL_RST;
        end else begin
            wr_pend_r <= take && hwrite_in;
            wr_addr_r <= a8;
            if (take && !hwrite_in)
                hrdata_out <= rd_mux;
            if (wr_pend_r && wr_addr_r == ADDR_CTRL)
                ctrl_r <= {31'h0, hwdata_in[CTRL_LOCK_BIT]};
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    sequence s_reset_steps;
        io_clear_out ##1 io_set_out;
    endsequence
    sequence s_dep_steps;
        (cmd_out == CMD_MEM_WR) ##1 (cmd_out == CMD_INC_PC) && cmd_valid_out;
    endsequence

    a_reset_order: assert property (go_reset |=> s_reset_steps) // see RL3
        else $error("reset order");
    a_reset_fanout: assert property (go_reset |=> // see RL1 see RL2 see RL4
        ime_clear_out && pfi_clear_out && force_fetch_out)
        else $error("reset fan-out");
    a_fault_lamp: assert property (fault_in |=> ##1 run_lamp_out) // see RL5
        else $error("fault lamp off");
    a_fault_hold: assert property (fault_r && !go_reset |=> fault_r) // see RL5
        else $error("fault latch dropped");
    a_stop_end: assert property ((state_r == ST_RUN) && stop_pend_r && phase_end_in // see RL7
        |=> ##1 !run_out && stop_lamp_out)
        else $error("stop missed phase end");
    a_step_one: assert property ((state_r == ST_STEP) && phase_end_in // see RL12
        |=> !run_out)
        else $error("step ran on");
    a_run_locks: assert property (running |=> !$rose(cmd_valid_out)) // see RL14
        else $error("command while running");
    a_dep_inc: assert property (cmd_valid_out && cmd_out == CMD_MEM_WR && cmd_done_in // see RL8
        |-> s_dep_steps)
        else $error("deposit without step");
    a_loader_gate: assert property (loader_ok_out |-> $past(loader_en)) // see RL15
        else $error("loader open while locked");
endmodule // occ_console
`default_nettype wire

// ==== hdl/occ_pkg.sv ====
package occ_pkg;
    // ------------------------------------------------------------
    // Widths and timing
    // ------------------------------------------------------------
    localparam int unsigned WORD_W = 16;
    localparam int unsigned CLK_KHZ = 10000;
    localparam int unsigned DEB_TIME_US = 5000;
    localparam int unsigned DEB_CYC = (DEB_TIME_US * CLK_KHZ) / 1000;
    localparam int unsigned NUM_KEYS = 9;

    // ------------------------------------------------------------
    // Key positions on key_in
    // ------------------------------------------------------------
    localparam int unsigned K_RESET = 0;
    localparam int unsigned K_RUN = 1;
    localparam int unsigned K_STOP = 2;
    localparam int unsigned K_DEPOSIT = 3;
    localparam int unsigned K_LOAD_A = 4;
    localparam int unsigned K_LOAD_B = 5;
    localparam int unsigned K_SET_ADDR = 6;
    localparam int unsigned K_EXAMINE = 7;
    localparam int unsigned K_STEP = 8;

    // ------------------------------------------------------------
    // Register map and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_CTRL = 8'h04;
    localparam logic [7:0] ADDR_SWITCH = 8'h08;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam int unsigned CTRL_LOCK_BIT = 0;

    // ------------------------------------------------------------
    // Processor commands
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CMD_NONE = 3'b000,
        CMD_MEM_WR = 3'b001,
        CMD_MEM_RD = 3'b010,
        CMD_LD_A = 3'b011,
        CMD_LD_B = 3'b100,
        CMD_LD_ADDR = 3'b101,
        CMD_INC_PC = 3'b110
    } occ_cmd_type;
endpackage

// ==== hdl/occ_key_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// Raw key in, press pulse out
interface occ_key_if;
    logic raw;
    logic press;
    modport deb (input raw, output press);
    modport ctl (output raw, input press);
endinterface
`default_nettype wire

// ==== hdl/occ_debounce.sv ====
`timescale 1ns/1ps
`default_nettype none
module occ_debounce #(
    parameter int unsigned DEB_CYCLES = occ_pkg::DEB_CYC,
    parameter int unsigned CNT_W = 16
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // Key
    occ_key_if.deb key
);
    import occ_pkg::*;

    logic s1_r, s2_r, s3_r, state_r, press_r;
    logic [CNT_W-1:0] cnt_r;
    wire agree = (s2_r == s3_r);
    wire differ = agree && (s3_r != state_r);
    wire settled = differ && (cnt_r == CNT_W'(DEB_CYCLES - 1));

    // ----------------------------------------------------------------
    // Synchroniser, settle counter, pulse
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            state_r <= 1'b0;
            cnt_r <= '0;
            press_r <= 1'b0;
        end else begin
            s1_r <= key.raw;
            s2_r <= s1_r;
            s3_r <= s2_r;
            cnt_r <= (differ && !settled) ? cnt_r + 1'b1 : '0; // see RL18
            if (settled)
                state_r <= s3_r;
            press_r <= settled && s3_r; // see RL18
        end
    end

    assign key.press = press_r;
endmodule // occ_debounce
`default_nettype wire

// ==== testbench/occ_cpu_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Processor stand-in
module occ_cpu_model
    import occ_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // Control from console
    input wire logic run_in,
    input wire logic force_fetch_in,
    input wire occ_cmd_type cmd_in,
    input wire logic cmd_valid_in,
    input wire logic [WORD_W-1:0] cmd_data_in,
    // State to console
    output logic cmd_done_out,
    output logic phase_end_out,
    output logic [2:0] phase_out,
    output logic [WORD_W-1:0] mdr_out,
    output logic [WORD_W-1:0] pc_out,
    output logic [WORD_W-1:0] mar_out,
    output logic [WORD_W-1:0] acc_a_out,
    output logic [WORD_W-1:0] acc_b_out
);
    logic [WORD_W-1:0] core_r [0:255];
    logic [2:0] pcnt_r;
    logic [1:0] ccnt_r;
    // ------------------------------------------------------------
    // Machine cycles and commands
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            {cmd_done_out, phase_end_out, pcnt_r, ccnt_r} <= '0;
            {mdr_out, pc_out, mar_out, acc_a_out, acc_b_out} <= '0;
            phase_out <= 3'b001;
        end else begin
            cmd_done_out <= 1'b0;
            phase_end_out <= 1'b0;
            pcnt_r <= run_in ? pcnt_r + 3'd1 : 3'd0;
            // Phase rotates per machine cycle
            if (run_in && pcnt_r == 3'd4) begin
                phase_end_out <= 1'b1;
                pcnt_r <= 3'd0;
                phase_out <= {phase_out[1:0], phase_out[2]};
            end
            if (force_fetch_in) phase_out <= 3'b001;
            // Commands take three cycles
            if (!cmd_valid_in) begin
                ccnt_r <= 2'd0;
            end else if (ccnt_r == 2'd2) begin
                cmd_done_out <= 1'b1;
                ccnt_r <= 2'd0;
                case (cmd_in)
                    CMD_MEM_WR: core_r[mar_out[7:0]] <= cmd_data_in;
                    CMD_MEM_RD: mdr_out <= core_r[mar_out[7:0]];
                    CMD_LD_A: acc_a_out <= cmd_data_in;
                    CMD_LD_B: acc_b_out <= cmd_data_in;
                    CMD_LD_ADDR: {pc_out, mar_out, phase_out} <= {cmd_data_in, cmd_data_in, 3'b001};
                    CMD_INC_PC: {pc_out, mar_out, phase_out} <= {pc_out + 16'h0001, pc_out + 16'h0001, 3'b001};
                    default: ;
                endcase
            end else begin
                ccnt_r <= ccnt_r + 2'd1;
            end
        end
    end
endmodule // occ_cpu_model
`default_nettype wire

// ==== testbench/operator_console_control_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module operator_console_control_tb;
    import occ_pkg::*;
    logic clk_in, rst_b_in, hsel_in, hwrite_in, hreadyout_out, hresp_out;
    logic [31:0] haddr_in, hwdata_in, hrdata_out, rd;
    logic [1:0] htrans_in;
    logic [2:0] hsize_in, phase_in, phase_lamp_out;
    logic [NUM_KEYS-1:0] key_in;
    logic [WORD_W-1:0] switch_in, mdr_in, pc_in, mar_in, acc_a_in, acc_b_in, cmd_data_out;
    logic [WORD_W-1:0] mdr_lamp_out, pc_lamp_out, mar_lamp_out, acc_a_lamp_out, acc_b_lamp_out;
    logic loader_en_in, pfail_in, overheat_in, phase_end_in, cmd_done_in;
    logic run_out, force_fetch_out, cmd_valid_out, loader_ok_out;
    logic io_clear_out, io_set_out, ime_clear_out, pfi_clear_out;
    logic run_lamp_out, stop_lamp_out, ext_lamp_out, ovf_lamp_out;
    occ_cmd_type cmd_out;
    int n_fail, compares, cyc, n_clr, n_set, n_ime, n_pfi, n_ff, n_pe, n0;
    time t_clr, t_set;
    // ------------------------------------------------------------
    // Design and processor
    // ------------------------------------------------------------
    occ_console #(.DEB_CYCLES(4)) dut_u (
        .clk_in, .rst_b_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hsize_in,
        .hwdata_in, .hready_in(hreadyout_out), .hreadyout_out, .hresp_out, .hrdata_out,
        .key_in, .switch_in, .loader_en_in, .pfail_in, .overheat_in, .phase_in,
        .phase_end_in, .ext_in(acc_a_in[15]), .ovf_in(acc_b_in[15]), .mdr_in, .pc_in,
        .mar_in, .acc_a_in, .acc_b_in, .run_out, .force_fetch_out, .cmd_out, .cmd_valid_out,
        .cmd_data_out, .cmd_done_in, .loader_ok_out, .io_clear_out, .io_set_out,
        .ime_clear_out, .pfi_clear_out, .run_lamp_out, .stop_lamp_out, .ext_lamp_out,
        .ovf_lamp_out, .phase_lamp_out, .mdr_lamp_out, .pc_lamp_out, .mar_lamp_out,
        .acc_a_lamp_out, .acc_b_lamp_out);
    occ_cpu_model cpu_u (
        .clk_in, .rst_b_in, .run_in(run_out), .force_fetch_in(force_fetch_out),
        .cmd_in(cmd_out), .cmd_valid_in(cmd_valid_out), .cmd_data_in(cmd_data_out),
        .cmd_done_out(cmd_done_in), .phase_end_out(phase_end_in), .phase_out(phase_in),
        .mdr_out(mdr_in), .pc_out(pc_in), .mar_out(mar_in), .acc_a_out(acc_a_in),
        .acc_b_out(acc_b_in));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task final_report;
        if (n_fail == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Press, hold, release
    task automatic press(input int k, input logic [15:0] sw);
        @(posedge clk_in);
        key_in[k] <= 1'b1;
        switch_in <= sw;
        repeat (12) @(posedge clk_in);
        key_in[k] <= 1'b0;
        repeat (24) @(posedge clk_in);
    endtask
    // One AHB-Lite transfer
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk_in);
        {hsel_in, htrans_in, haddr_in, hwrite_in, hsize_in} <= {1'b1, 2'b10, 24'h0, a, wr, 3'b010};
        do @(posedge clk_in); while (hreadyout_out !== 1'b1);
        {hsel_in, htrans_in, hwdata_in} <= {1'b0, 2'b00, wd};
        do @(posedge clk_in); while (hreadyout_out !== 1'b1);
        rd = hrdata_out;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_reset_key;
        repeat (2) @(posedge clk_in);
        chk("run lamp power-up", run_lamp_out, 1);
        chk("stop lamp idle", stop_lamp_out, 1);
        press(K_RESET, 16'h0000);
        chk("io clear", n_clr, 1);
        chk("io set", n_set, 1);
        chk("clear then set", t_set > t_clr, 1);
        chk("ime clear", n_ime, 1);
        chk("pfi clear", n_pfi, 1);
        chk("force fetch", n_ff, 1);
        chk("run lamp cleared", run_lamp_out, 0);
    endtask
    task t_mem_keys;
        press(K_SET_ADDR, 16'h0010);
        chk("pc set", pc_lamp_out, 16'h0010);
        chk("mar set", mar_lamp_out, 16'h0010);
        chk("fetch", phase_lamp_out, 3'b001);
        press(K_DEPOSIT, 16'h1234);
        chk("pc dep", pc_lamp_out, 16'h0011);
        chk("mar dep", mar_lamp_out, 16'h0011);
        press(K_SET_ADDR, 16'h0010);
        press(K_EXAMINE, 16'h0000);
        chk("mdr exam", mdr_lamp_out, 16'h1234);
        chk("pc exam", pc_lamp_out, 16'h0011);
        chk("mar exam", mar_lamp_out, 16'h0011);
        chk("fetch exam", phase_lamp_out, 3'b001);
    endtask
    task t_acc_keys;
        press(K_LOAD_A, 16'h8001);
        chk("acc a", acc_a_lamp_out, 16'h8001);
        chk("ext lamp", ext_lamp_out, 1);
        press(K_LOAD_B, 16'h8000);
        chk("acc b", acc_b_lamp_out, 16'h8000);
        chk("ovf lamp", ovf_lamp_out, 1);
    endtask
    task t_step;
        n0 = n_pe;
        press(K_STEP, 16'h0000);
        chk("one cycle", n_pe - n0, 1);
        chk("halted", run_out, 0);
        chk("phase moved", phase_lamp_out, 3'b010);
    endtask
    task t_run_stop;
        press(K_RUN, 16'h0000);
        chk("running", run_out, 1);
        chk("run lamp", run_lamp_out, 1);
        chk("stop lamp off", stop_lamp_out, 0);
        press(K_LOAD_A, 16'h5555);
        chk("lockout", acc_a_lamp_out, 16'h8001);
        press(K_STOP, 16'h0000);
        chk("stopped", run_out, 0);
        chk("stop lamp", stop_lamp_out, 1);
        chk("one-hot", $countones(phase_lamp_out), 1);
    endtask
    task t_regs;
        switch_in <= 16'ha5c3;
        loader_en_in <= 1'b1;
        repeat (10) @(posedge clk_in);
        bus(1'b0, ADDR_SWITCH, 32'h0);
        chk("switch word", rd, 32'h0000a5c3);
        chk("loader ok", loader_ok_out, 1);
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk("status bits", rd[7:5], 3'b010);
        bus(1'b1, ADDR_CTRL, 32'h1);
        bus(1'b0, ADDR_CTRL, 32'h0);
        chk("ctrl", rd, 32'h1);
        press(K_LOAD_B, 16'h7777);
        chk("panel lock", acc_b_lamp_out, 16'h8000);
        bus(1'b1, ADDR_CTRL, 32'h0);
        bus(1'b0, 8'h0c, 32'h0);
        chk("unmapped", rd, 32'h0);
        chk("hresp", hresp_out, 0);
        loader_en_in <= 1'b0;
        repeat (10) @(posedge clk_in);
        chk("loader shut", loader_ok_out, 0);
    endtask
    task t_faults;
        overheat_in <= 1'b1;
        repeat (10) @(posedge clk_in);
        chk("overheat lamp", run_lamp_out, 1);
        press(K_RESET, 16'h0000);
        chk("fault persists", run_lamp_out, 1);
        overheat_in <= 1'b0;
        press(K_RESET, 16'h0000);
        chk("fault cleared", run_lamp_out, 0);
        pfail_in <= 1'b1;
        repeat (10) @(posedge clk_in);
        pfail_in <= 1'b0;
        repeat (10) @(posedge clk_in);
        chk("pfail latched", run_lamp_out, 1);
    endtask
    // ------------------------------------------------------------
    // Clock, pulse counters and timeout
    // ------------------------------------------------------------
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        cyc++;
        if (io_clear_out === 1'b1) {n_clr, t_clr} = {n_clr + 1, $time};
        if (io_set_out === 1'b1) {n_set, t_set} = {n_set + 1, $time};
        if (ime_clear_out === 1'b1) n_ime++;
        if (pfi_clear_out === 1'b1) n_pfi++;
        if (force_fetch_out === 1'b1) n_ff++;
        if (phase_end_in === 1'b1) n_pe++;
        if (cyc == 20000) begin
            n_fail++;
            final_report;
        end
    end
    // Main sequence
    initial begin
        {rst_b_in, hsel_in, haddr_in, htrans_in, hwrite_in, hsize_in, hwdata_in} = '0;
        {key_in, switch_in, loader_en_in, pfail_in, overheat_in} = '0;
        repeat (12) @(posedge clk_in);
        rst_b_in <= 1'b1;
        t_reset_key;
        t_mem_keys;
        t_acc_keys;
        t_step;
        t_run_stop;
        t_regs;
        t_faults;
        final_report;
    end
endmodule // operator_console_control_tb
`default_nettype wire
